// >>> rtl/eeprom_link_pkg.sv
package eeprom_link_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS = 8000000;
  // Longest time: rounds down
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int SCL_QUARTER_NS = 1000;
  localparam int SCL_QUARTER_CYCLES = SCL_QUARTER_NS / CLK_PERIOD_NS;
  localparam int ADDR_W = 11;
  localparam int MEM_BYTES = 2048;
  localparam int PAGE_BITS = 4;
  localparam int PAGES = 128;
  localparam int FIFO_DEPTH = 2;
  localparam logic [3:0] DEVICE_PATTERN = 4'hA;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;
  localparam logic [4:0] TICK_RESET = 5'h00;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_CMD = 3'h1,
    S_ADDR = 3'h2,
    S_WDATA = 3'h3,
    S_RDATA = 3'h4,
    S_IGNORE = 3'h5
  } dev_state_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_START = 3'h1,
    M_LOAD = 3'h2,
    M_BYTE = 3'h3,
    M_STOP = 3'h4
  } mst_state_t;

  typedef enum logic [2:0] {
    K_CSW = 3'h0,
    K_ADDR = 3'h1,
    K_WDATA = 3'h2,
    K_CSR = 3'h3,
    K_RDATA = 3'h4
  } byte_kind_t;
endpackage : eeprom_link_pkg

// >>> rtl/i2c_link_if.sv
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_out;
  logic scl_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // Pull-up resolution of the open-drain wires
  assign scl = scl_oe ? scl_out : 1'b1;
  assign sda = (sda_m_oe ? sda_m_out : 1'b1) & (sda_s_oe ? sda_s_out : 1'b1);

  modport master (
    output scl_out, scl_oe, sda_m_out, sda_m_oe,
    input scl, sda
  );
  modport eeprom (
    output sda_s_out, sda_s_oe,
    input scl, sda
  );
endinterface : i2c_link_if

// >>> rtl/eeprom_slave.sv
`timescale 1ns/1ps
// Summary of operation
// - Write command: pattern, A10..A8, bit0 zero
// - Read command: pattern, bits 3..1 ignored, bit0 one
// - Byte after write command loads low address
// - Accepted write command acknowledged in ninth clock
// - Address advances after each acknowledged data byte
// - Stop after write data starts erase/write cycle
// - Erase/write cycle finishes within 8 ms
// - Page write takes one to sixteen bytes
// - Only low four address bits advance in a page write
// - Unaddressed page bytes stay unchanged
// - No command acknowledge while programming
// - After programming, counter holds last entered address
// - Random read: address, repeated start, read command
// - Read sends addressed byte MSB first, increments
// - Plain read command uses current counter
// - Master acknowledge continues with next byte
// - Sequential read wraps top address to zero
// - Master ends read with no acknowledge, stop
// - One protection bit per 16-byte page
// - Written protection bit blocks page changes
// - Write-protect pin high blocks all changes
// - Programming of protected page is suppressed
// - Start/stop change data while clock high
module eeprom_slave
  import eeprom_link_pkg::*;
#(
  parameter int PROG_TICKS = PROG_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  i2c_link_if.eeprom link,
  input wire logic wp,
  input wire logic [PAGES-1:0] page_unlocked,
  output logic busy
);
  localparam int TW = $clog2(PROG_TICKS + 1);
  localparam int PW = ADDR_W - PAGE_BITS;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] wp_sync;
    logic scl_prev;
    logic sda_prev;
    dev_state_t st;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [2:0] hi;
    logic [ADDR_W-1:0] addr;
    logic [15:0][7:0] page_buf;
    logic [15:0] sel;
    logic have_data;
    logic sda_low;
    logic prog;
    logic [TW-1:0] timer;
    logic [PW-1:0] prog_page;
  } dev_reg_t;

  dev_reg_t r;
  dev_reg_t next_r;

  logic [7:0] mem [MEM_BYTES];
  logic [7:0] mem_rd;
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic scl_now;
  logic sda_now;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [3:0] prog_idx;

  assign scl_now = r.scl_sync[1];
  assign sda_now = r.sda_sync[1];
  assign scl_rise = scl_now & ~r.scl_prev;
  assign scl_fall = ~scl_now & r.scl_prev;
  assign start_seen = scl_now & r.scl_prev & ~sda_now & r.sda_prev;
  assign stop_seen = scl_now & r.scl_prev & sda_now & ~r.sda_prev;
  assign mem_rd = mem[r.addr];

  // First 16 ticks erase, next 16 write, one byte per tick
  assign prog_idx = r.timer[3:0];
  assign mem_wa = {r.prog_page, prog_idx};
  assign mem_wd = r.timer[4] ? r.page_buf[prog_idx] : ERASED_BYTE;
  assign mem_we = r.prog && (r.timer[TW-1:5] == '0) && r.sel[prog_idx];

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_comb begin
    next_r = r;
    next_r.scl_sync = {r.scl_sync[0], link.scl};
    next_r.sda_sync = {r.sda_sync[0], link.sda};
    next_r.wp_sync = {r.wp_sync[0], wp};
    next_r.scl_prev = scl_now;
    next_r.sda_prev = sda_now;

    if (r.prog) begin
      if (r.timer == TW'(PROG_TICKS - 1)) begin
        next_r.prog = 1'b0;
        next_r.timer = '0;
      end else begin
        next_r.timer = r.timer + 1'b1;
      end
    end

    if (start_seen) begin
      // A repeated start drops any pending write data
      next_r.st = S_CMD;
      // The clock fall that closes the start is not a data bit
      next_r.bcnt = 4'hF;
      next_r.sda_low = 1'b0;
      next_r.have_data = 1'b0;
    end else if (stop_seen) begin
      next_r.st = S_IDLE;
      next_r.sda_low = 1'b0;
      next_r.have_data = 1'b0;
      if (r.st == S_WDATA && r.have_data) begin
        next_r.addr[3:0] = r.addr[3:0] - 4'h1;
        if (!r.wp_sync[1] && page_unlocked[r.addr[ADDR_W-1:PAGE_BITS]]) begin
          next_r.prog = 1'b1;
          next_r.timer = '0;
          next_r.prog_page = r.addr[ADDR_W-1:PAGE_BITS];
        end
      end
    end else if (scl_rise) begin
      if (r.bcnt != BIT_ACK && r.st != S_RDATA) begin
        next_r.sh = {r.sh[6:0], sda_now};
      end else if (r.bcnt == BIT_ACK && r.st == S_RDATA && sda_now) begin
        next_r.st = S_IGNORE;
      end
    end else if (scl_fall) begin
      next_r.bcnt = r.bcnt + 4'h1;
      if (r.st == S_RDATA) begin
        if (r.bcnt == BIT_ACK) begin
          next_r.bcnt = 4'h0;
          next_r.sh = mem_rd;
          next_r.sda_low = ~mem_rd[7];
          next_r.addr = r.addr + 1'b1;
        end else if (r.bcnt == BIT_LAST) begin
          next_r.sda_low = 1'b0;
        end else begin
          next_r.sh = {r.sh[6:0], 1'b0};
          next_r.sda_low = ~r.sh[6];
        end
      end else if (r.st == S_CMD || r.st == S_ADDR || r.st == S_WDATA) begin
        if (r.bcnt == BIT_LAST) begin
          case (r.st)
            S_CMD: begin
              if (r.sh[7:4] == DEVICE_PATTERN && !r.prog) begin
                next_r.sda_low = 1'b1;
                if (r.sh[0]) begin
                  next_r.st = S_RDATA;
                end else begin
                  next_r.st = S_ADDR;
                  next_r.hi = r.sh[3:1];
                end
              end else begin
                next_r.st = S_IGNORE;
              end
            end
            S_ADDR: begin
              next_r.addr = {r.hi, r.sh};
              next_r.sda_low = 1'b1;
              next_r.st = S_WDATA;
              next_r.sel = 16'h0000;
              next_r.have_data = 1'b0;
            end
            S_WDATA: begin
              // More than 16 bytes wrap and overwrite the page buffer
              next_r.page_buf[r.addr[3:0]] = r.sh;
              next_r.sel[r.addr[3:0]] = 1'b1;
              next_r.have_data = 1'b1;
              next_r.addr[3:0] = r.addr[3:0] + 4'h1;
              next_r.sda_low = 1'b1;
            end
            default: begin
              next_r.st = S_IGNORE;
            end
          endcase
        end else if (r.bcnt == BIT_ACK) begin
          next_r.sda_low = 1'b0;
          next_r.bcnt = 4'h0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{
        scl_sync: 2'h3, sda_sync: 2'h3, wp_sync: 2'h0,
        scl_prev: 1'b1, sda_prev: 1'b1, st: S_IDLE,
        addr: ADDR_RESET, default: '0
      };
    end else begin
      r <= next_r;
    end
  end

  assign busy = r.prog;
  assign link.sda_s_oe = r.sda_low;
  assign link.sda_s_out = 1'b0;
endmodule : eeprom_slave

// >>> rtl/i2c_eeprom_master.sv
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [DEPTH-1:0][WIDTH-1:0] slot;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Pointers wrap naturally: depth must be a power of two
  assign in_ready = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = slot[rd_ptr];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : byte_fifo

module i2c_eeprom_master
  import eeprom_link_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  i2c_link_if.master link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_set_addr,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [3:0] cmd_len,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic done,
  output logic failed
);
  typedef struct packed {
    logic [1:0] sda_sync;
    mst_state_t st;
    byte_kind_t kind;
    logic [1:0] q;
    logic [4:0] tick;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic rd_op;
    logic [ADDR_W-1:0] addr;
    logic [3:0] left;
    logic scl_low;
    logic sda_low;
    logic push;
    logic done;
    logic failed;
  } mst_reg_t;

  mst_reg_t r;
  mst_reg_t next_r;
  logic step;
  logic fifo_ready;
  logic sda_in;

  assign sda_in = r.sda_sync[1];
  assign step = (r.tick == 5'(SCL_QUARTER_CYCLES - 1));
  assign cmd_ready = (r.st == M_IDLE);
  assign wr_ready = (r.st == M_LOAD) && (r.kind == K_WDATA);

  always_comb begin
    next_r = r;
    next_r.sda_sync = {r.sda_sync[0], link.sda};
    next_r.push = 1'b0;
    next_r.done = 1'b0;
    if (r.st != M_IDLE && r.st != M_LOAD) begin
      next_r.tick = step ? TICK_RESET : r.tick + 5'h01;
    end
    case (r.st)
      M_IDLE: begin
        if (cmd_valid) begin
          next_r.rd_op = cmd_read;
          next_r.addr = cmd_addr;
          next_r.left = cmd_len;
          next_r.failed = 1'b0;
          next_r.st = M_START;
          next_r.q = 2'h0;
          next_r.tick = TICK_RESET;
          if (cmd_read && !cmd_set_addr) begin
            next_r.kind = K_CSR;
            next_r.sh = {DEVICE_PATTERN, 3'h0, 1'b1};
          end else begin
            next_r.kind = K_CSW;
            next_r.sh = {DEVICE_PATTERN, cmd_addr[10:8], 1'b0};
          end
        end
      end
      M_START: begin
        if (step) begin
          next_r.q = r.q + 2'h1;
          case (r.q)
            2'h0: next_r.sda_low = 1'b0;
            2'h1: next_r.scl_low = 1'b0;
            2'h2: next_r.sda_low = 1'b1;
            default: begin
              next_r.scl_low = 1'b1;
              next_r.st = M_BYTE;
              next_r.bcnt = 4'h0;
            end
          endcase
        end
      end
      M_LOAD: begin
        if (r.kind == K_WDATA && wr_valid) begin
          next_r.sh = wr_data;
          next_r.st = M_BYTE;
        end else if (r.kind == K_RDATA && fifo_ready) begin
          next_r.st = M_BYTE;
        end
        next_r.q = 2'h0;
        next_r.bcnt = 4'h0;
        next_r.tick = TICK_RESET;
      end
      M_BYTE: begin
        if (step) begin
          next_r.q = r.q + 2'h1;
          case (r.q)
            2'h0: begin
              // Data changes only with the clock low
              if (r.bcnt != BIT_ACK) begin
                next_r.sda_low = (r.kind != K_RDATA) && !r.sh[7];
              end else begin
                next_r.sda_low = (r.kind == K_RDATA) && (r.left != 4'h0);
              end
            end
            2'h1: next_r.scl_low = 1'b0;
            2'h2: next_r.scl_low = 1'b0;
            default: begin
              next_r.scl_low = 1'b1;
              next_r.bcnt = r.bcnt + 4'h1;
              if (r.bcnt != BIT_ACK) begin
                next_r.sh = {r.sh[6:0], sda_in};
                next_r.push = (r.kind == K_RDATA) && (r.bcnt == BIT_LAST);
              end else if (r.kind != K_RDATA && sda_in) begin
                next_r.failed = 1'b1;
                next_r.st = M_STOP;
              end else begin
                case (r.kind)
                  K_CSW: begin
                    next_r.kind = K_ADDR;
                    next_r.sh = r.addr[7:0];
                    next_r.bcnt = 4'h0;
                  end
                  K_ADDR: begin
                    if (r.rd_op) begin
                      next_r.kind = K_CSR;
                      next_r.sh = {DEVICE_PATTERN, 3'h0, 1'b1};
                      next_r.st = M_START;
                    end else begin
                      next_r.kind = K_WDATA;
                      next_r.st = M_LOAD;
                    end
                  end
                  K_CSR: begin
                    next_r.kind = K_RDATA;
                    next_r.st = M_LOAD;
                  end
                  default: begin
                    if (r.left == 4'h0) begin
                      next_r.st = M_STOP;
                    end else begin
                      next_r.left = r.left - 4'h1;
                      next_r.st = M_LOAD;
                    end
                  end
                endcase
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (step) begin
          next_r.q = r.q + 2'h1;
          case (r.q)
            2'h0: next_r.sda_low = 1'b1;
            2'h1: next_r.scl_low = 1'b0;
            2'h2: next_r.sda_low = 1'b0;
            default: begin
              next_r.st = M_IDLE;
              next_r.done = 1'b1;
            end
          endcase
        end
      end
      default: begin
        next_r.st = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{sda_sync: 2'h3, st: M_IDLE, kind: K_CSW, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // A read byte starts only with room held, so a push never drops
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(r.push),
    .in_ready(fifo_ready),
    .in_data(r.sh),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign done = r.done;
  assign failed = r.failed;
  assign link.scl_oe = r.scl_low;
  assign link.scl_out = 1'b0;
  assign link.sda_m_oe = r.sda_low;
  assign link.sda_m_out = 1'b0;
endmodule : i2c_eeprom_master

// >>> test/eeprom_link_monitor.sv
`timescale 1ns/1ps
module eeprom_link_monitor
  import eeprom_link_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe
);
  logic scl_q, sda_q, first, rd;
  logic [3:0] bitn;
  logic [7:0] sh;
  wire logic rise = !scl_q && scl;
  wire logic start = scl_q && scl && sda_q && !sda;
  wire logic stop = scl_q && scl && !sda_q && sda;

  // Bit position since the last start, to find the ninth clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bitn <= 4'h0;
      first <= 1'b0;
      rd <= 1'b0;
      sh <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        bitn <= 4'h0;
        first <= 1'b1;
      end else if (rise) begin
        bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
        sh <= {sh[6:0], sda};
        if (bitn == 4'h8) first <= 1'b0;
        if (first && bitn == 4'h7) rd <= sda;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence high_8;
    scl[*8];
  endsequence
  sequence cmd_ack;
    rise && first && bitn == 4'h8 && sda_s_oe;
  endsequence

  slave_launch_low_a: assert property (
    $rose(sda_s_oe) |-> !scl && !$past(scl, 2))
    else $error("slave pulled data outside clock low");
  slave_hold_high_a: assert property (
    scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave data moved while clock high");
  ack_ninth_clock_a: assert property (
    rise && sda_s_oe && (!rd || first) |-> bitn == 4'h8)
    else $error("slave drove low outside the ack slot");
  read_ack_free_a: assert property (
    rise && rd && !first && bitn == 4'h8 |-> !sda_s_oe)
    else $error("slave held data in master ack slot");
  pattern_ack_a: assert property (
    cmd_ack |-> sh[7:4] == DEVICE_PATTERN)
    else $error("slave acknowledged a foreign pattern");
  stop_release_a: assert property (
    stop |-> ##[0:4] !sda_s_oe)
    else $error("slave still driving after stop");
  clock_high_a: assert property (
    $rose(scl) |-> high_8)
    else $error("clock high phase too short");
  start_hold_a: assert property (
    start |-> sda_m_oe ##0 high_8)
    else $error("clock fell right after start");
endmodule : eeprom_link_monitor

// >>> test/tb_serial_eeprom_slave_protocol.sv
`timescale 1ns/1ps
module tb_serial_eeprom_slave_protocol;
  localparam int TICKS = 2000;
  localparam int LIMIT = 100000;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp = 1'b0;
  logic [127:0] page_unlocked = '1;
  logic cmd_valid = 1'b0, cmd_read = 1'b0, cmd_set_addr = 1'b0;
  logic [10:0] cmd_addr = 11'h000;
  logic [3:0] cmd_len = 4'h0;
  logic wr_valid = 1'b0, rd_ready = 1'b1;
  logic [7:0] wr_data = 8'h00;
  logic busy, cmd_ready, wr_ready, rd_valid, done, failed;
  logic [7:0] rd_data;
  logic [7:0] mem [0:2047];
  logic [7:0] wq[$], rq[$];
  int err_total = 0, cmp_count = 0, cyc = 0;

  i2c_link_if link ();

  always #20 ref_clk = ~ref_clk;

  eeprom_slave #(.PROG_TICKS(TICKS)) eeprom_slave_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .link(link.eeprom), .wp(wp),
    .page_unlocked(page_unlocked), .busy(busy));
  i2c_eeprom_master i2c_eeprom_master_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link.master), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_set_addr(cmd_set_addr), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .done(done), .failed(failed));
  eeprom_link_monitor eeprom_link_monitor_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .scl(link.scl), .sda(link.sda),
    .sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe));

  task automatic tally_and_finish();
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8

  task automatic cmp1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp1

  // Write stream: offer queued bytes, pop on handshake
  always @(posedge ref_clk) begin
    if (wr_valid && wr_ready) void'(wq.pop_front());
    #1;
    wr_valid = (wq.size() != 0);
    wr_data = wr_valid ? wq[0] : 8'h00;
  end

  // Read stream with long stalls, so the two-entry buffer fills up
  always @(posedge ref_clk) begin
    if (rd_valid && rd_ready) rq.push_back(rd_data);
    #1;
    rd_ready = !(cyc[12] && cyc[11]);
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic xfer(input logic rd, input logic sa, input logic [10:0] a,
                      input logic [3:0] len);
    int n;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_set_addr = sa;
    cmd_addr = a;
    cmd_len = len;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    // A transfer that never completes is a hang, not a pass
    if (done !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
  endtask : xfer

  task automatic settle(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (TICKS + 200) begin
      @(posedge ref_clk);
      #1;
      if (busy === 1'b1) seen = 1'b1;
    end
    cmp1("busy seen", exp, seen);
    cmp1("busy end", 1'b0, busy);
  endtask : settle

  task automatic write_pg(input logic [10:0] a, input int n,
                          input logic [7:0] base, input logic prog,
                          input logic poll);
    logic [10:0] t;
    for (int i = 0; i < n; i++) begin
      t = {a[10:4], a[3:0] + 4'(i)};
      wq.push_back(base + 8'(i));
      if (prog) mem[t] = base + 8'(i);
    end
    xfer(1'b0, 1'b0, a, 4'(n - 1));
    cmp1("write failed", 1'b0, failed);
    if (poll) begin
      xfer(1'b1, 1'b0, a, 4'h0);
      cmp1("poll failed", 1'b1, failed);
    end
    settle(prog);
  endtask : write_pg

  task automatic read_chk(input logic sa, input logic [10:0] a, input int n);
    int k;
    rq.delete();
    xfer(1'b1, sa, a, 4'(n - 1));
    cmp1("read failed", 1'b0, failed);
    k = 0;
    while (rq.size() < n && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    cmp8("read count", 8'(n), 8'(rq.size()));
    for (int i = 0; i < rq.size(); i++) begin
      cmp8("read byte", mem[11'(a + 11'(i))], rq[i]);
    end
  endtask : read_chk

  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    write_pg(11'h120, 16, 8'h30, 1'b1, 1'b1);
    write_pg(11'h12E, 3, 8'h80, 1'b1, 1'b0);
    wp = 1'b1;
    write_pg(11'h125, 1, 8'h55, 1'b0, 1'b0);
    wp = 1'b0;
    page_unlocked[7'h12] = 1'b0;
    write_pg(11'h12A, 2, 8'h66, 1'b0, 1'b0);
    page_unlocked[7'h12] = 1'b1;
    read_chk(1'b1, 11'h120, 16);
    write_pg(11'h000, 1, 8'hC3, 1'b1, 1'b0);
    write_pg(11'h7FF, 1, 8'h3C, 1'b1, 1'b0);
    read_chk(1'b0, 11'h7FF, 2);
    tally_and_finish();
  end
endmodule : tb_serial_eeprom_slave_protocol
